// [design/sfb_bank.sv]
/*
 * shared register bank: 32 doubles, seen also as 16 quads, with a
 * lane-wise vector port and a scalar fp read/write port.
 * assumes both execution pipelines run on clk and hold requests one cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module sfb_bank
   import sfb_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire sfb_pkg::sfb_vreq_s vreq,
   output logic [QREG_W-1:0] vres_r,
   output logic vdone_r,
   output logic vrefused_r,
   input wire sfb_pkg::sfb_sreq_s sreq,
   output logic [DREG_W-1:0] sdata_r
);
   import sfb_pkg::*;

   logic [DREG_W-1:0] dreg_r [NUM_D];

   function automatic logic [QREG_W-1:0] read_view(
      input logic [DREG_W-1:0] lo, input logic [DREG_W-1:0] hi,
      input logic quad);
      return quad ? {hi, lo} : {{DREG_W{1'b0}}, lo};
   endfunction : read_view

   // quad n maps onto doubles 2n and 2n+1
   wire [IDX_W-1:0] a_lo =
      vreq.quad ? {vreq.srca[3:0], 1'b0} : vreq.srca;
   wire [IDX_W-1:0] b_lo = vreq.quad ? {vreq.srcb[3:0], 1'b0} : vreq.srcb;
   wire [IDX_W-1:0] d_lo = vreq.quad ? {vreq.dst[3:0], 1'b0} : vreq.dst;
   wire [IDX_W-1:0] a_hi = a_lo | 5'h1;
   wire [IDX_W-1:0] b_hi = b_lo | 5'h1;
   wire [IDX_W-1:0] d_hi = d_lo | 5'h1;
   wire [QREG_W-1:0] opa =
      read_view(dreg_r[a_lo], dreg_r[a_hi], vreq.quad);
   wire [QREG_W-1:0] opb = read_view(dreg_r[b_lo], dreg_r[b_hi], vreq.quad);

   // request legality
   wire is_flt = (vreq.etype.kind == K_FLT);
   wire is_fop = (vreq.op == OP_FNEG) || (vreq.op == OP_FABS);
   wire bad_idx = vreq.quad && (vreq.dst[4] || vreq.srca[4] || vreq.srcb[4]);
   wire bad_flt = is_flt && (vreq.etype.size == SZ_64 ||
      vreq.etype.size == SZ_8);
   wire bad_mix = is_flt != is_fop;
   wire bad_poly = (vreq.op == OP_PMUL) != (vreq.etype.kind == K_POLY) ||
      (vreq.etype.kind == K_POLY && vreq.etype.size != SZ_8);
   wire bad_kind = vreq.etype.kind > K_POLY;
   wire vlegal = ~(bad_idx | bad_flt | bad_mix | bad_poly | bad_kind);
   wire vwr = vreq.valid && vlegal;
   wire [QREG_W-1:0] alu_y;
   // double view keeps only a 64-bit vector
   wire [QREG_W-1:0] vres_nxt = vreq.quad ? alu_y :
      {{DREG_W{1'b0}}, alu_y[DREG_W-1:0]};

   sfb_lane_alu u_alu (
      .a(opa),
      .b(opb),
      .op(vreq.op),
      .etype(vreq.etype),
      .y(alu_y)
   );

   // vector write wins a same-cycle clash with the scalar port
   wire s_clash = vwr && (sreq.wr_idx == d_lo ||
      (vreq.quad && sreq.wr_idx == d_hi));
   wire swr = sreq.wr_en && ~s_clash;

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         for (int i = 0; i < NUM_D; i++)
            dreg_r[i] <= DREG_RST;
      end
      else
      begin
         if (swr)
            dreg_r[sreq.wr_idx] <= sreq.wr_data;
         if (vwr)
         begin
            dreg_r[d_lo] <= vres_nxt[DREG_W-1:0];
            if (vreq.quad)
               dreg_r[d_hi] <= vres_nxt[QREG_W-1:DREG_W];
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         vres_r <= '0;
         vdone_r <= 1'b0;
         vrefused_r <= 1'b0;
         sdata_r <= DREG_RST;
      end
      else
      begin
         vres_r <= vwr ? vres_nxt : vres_r;
         vdone_r <= vwr;
         vrefused_r <= vreq.valid && ~vlegal;
         sdata_r <= dreg_r[sreq.rd_idx];
      end
   end

   chk_view_alias: assert property (
      @(posedge clk) disable iff (sys_rst)
      vreq.quad && !vreq.srca[4] |->
         opa == {dreg_r[{vreq.srca[3:0], 1'b1}],
                 dreg_r[{vreq.srca[3:0], 1'b0}]})
      else $error("quad view does not match its double pair");

   chk_quad_write: assert property (
      @(posedge clk) disable iff (sys_rst)
      vwr && vreq.quad |=>
         {dreg_r[$past(d_hi)], dreg_r[$past(d_lo)]} == $past(vres_nxt))
      else $error("quad write not visible in double view");

   chk_shared_bank: assert property (
      @(posedge clk) disable iff (sys_rst)
      swr ##1 (sreq.rd_idx == $past(sreq.wr_idx)) |=>
         sdata_r == $past(sreq.wr_data, 2))
      else $error("scalar write not seen by shared bank");

   chk_lane8_carry: assert property (
      @(posedge clk) disable iff (sys_rst)
      vreq.valid && vreq.op == OP_ADD && vreq.etype.size == SZ_8 |->
         alu_y[15:8] == 8'(opa[15:8] + opb[15:8]))
      else $error("carry crossed an 8-bit lane");

   chk_lane16_sub: assert property (
      @(posedge clk) disable iff (sys_rst)
      vreq.valid && vreq.op == OP_SUB && vreq.etype.size == SZ_16 |->
         alu_y[31:16] == 16'(opa[31:16] - opb[31:16]))
      else $error("borrow crossed a 16-bit lane");

   chk_poly_type: assert property (
      @(posedge clk) disable iff (sys_rst)
      vreq.valid && vreq.op == OP_PMUL && vreq.etype.kind != K_POLY
      |=> vrefused_r && !vdone_r)
      else $error("polynomial multiply taken on non-poly type");

   chk_vec_single: assert property (
      @(posedge clk) disable iff (sys_rst)
      vreq.valid && is_flt && vreq.etype.size == SZ_64
      |=> vrefused_r && !vdone_r)
      else $error("vector accepted double-precision float");

   chk_double_view: assert property (
      @(posedge clk) disable iff (sys_rst)
      vwr && !vreq.quad && !(swr && sreq.wr_idx == (vreq.dst ^ 5'h1))
      |=> dreg_r[$past(vreq.dst) ^ 5'h1] ==
         $past(dreg_r[vreq.dst ^ 5'h1]))
      else $error("64-bit vector write touched partner double");

   // upper half of a double-view result must read as zero
   chk_double_hi_zero: assert property (
      @(posedge clk) disable iff (sys_rst)
      vwr && !vreq.quad |=> vres_r[QREG_W-1:DREG_W] == '0)
      else $error("double-view result carries an upper half");

   chk_double_read: assert property (
      @(posedge clk) disable iff (sys_rst)
      !vreq.quad |-> opa == {{DREG_W{1'b0}}, dreg_r[vreq.srca]})
      else $error("double view does not read one register");

   chk_bad_quad_idx: assert property (
      @(posedge clk) disable iff (sys_rst)
      vreq.valid && vreq.quad && vreq.dst[4] |=> vrefused_r && !vdone_r)
      else $error("quad index above fifteen was accepted");

   chk_lane32_carry: assert property (
      @(posedge clk) disable iff (sys_rst)
      vreq.valid && vreq.op == OP_ADD && vreq.etype.size == SZ_32 |->
         alu_y[63:32] == 32'(opa[63:32] + opb[63:32]))
      else $error("carry crossed a 32-bit lane");

   chk_fneg_sign: assert property (
      @(posedge clk) disable iff (sys_rst)
      vreq.valid && vreq.op == OP_FNEG && vreq.etype.size == SZ_32 |->
         alu_y[31] == !opa[31] && alu_y[30:0] == opa[30:0])
      else $error("float negate did not flip only the lane sign");

   // a dropped scalar write must not leak past the vector result
   chk_vec_wins: assert property (
      @(posedge clk) disable iff (sys_rst)
      vwr && !vreq.quad |=>
         dreg_r[$past(d_lo)] == $past(vres_nxt[DREG_W-1:0]))
      else $error("vector write lost to a scalar write");

   chk_refuse_keeps: assert property (
      @(posedge clk) disable iff (sys_rst)
      vreq.valid && !vlegal && !(swr && sreq.wr_idx == d_lo) |=>
         dreg_r[$past(d_lo)] == $past(dreg_r[d_lo]))
      else $error("refused request changed the bank");

   // first edge after reset has no sampled read to compare against
   chk_scalar_read: assert property (
      @(posedge clk) disable iff (sys_rst)
      !$past(sys_rst) |-> sdata_r == $past(dreg_r[sreq.rd_idx]))
      else $error("scalar read did not return the bank word");

   cov_quad_add: cover property (@(posedge clk) disable iff (sys_rst)
      vwr && vreq.quad && vreq.op == OP_ADD);
   cov_refused: cover property (@(posedge clk) disable iff (sys_rst)
      vrefused_r);
   cov_clash: cover property (@(posedge clk) disable iff (sys_rst)
      s_clash && sreq.wr_en);
   cov_double_sub: cover property (@(posedge clk) disable iff (sys_rst)
      vwr && !vreq.quad && vreq.op == OP_SUB);
   cov_float_neg: cover property (@(posedge clk) disable iff (sys_rst)
      vwr && vreq.op == OP_FNEG);
endmodule : sfb_bank
`default_nettype wire

// [design/sfb_lane_alu.sv]
/*
 * combinational lane-wise alu over a 128-bit operand pair.
 * assumes the caller has already refused illegal op/type pairs.
 */
`timescale 1ns/1ps
`default_nettype none
module sfb_lane_alu
   import sfb_pkg::*;
(
   input wire logic [QREG_W-1:0] a,
   input wire logic [QREG_W-1:0] b,
   input wire sfb_pkg::sfb_op_e op,
   input wire sfb_pkg::sfb_etype_s etype,
   output logic [QREG_W-1:0] y
);
   localparam int NB = QREG_W / 8;

   // carry-less product, low byte only
   function automatic logic [7:0] clmul8(input logic [7:0] x,
                                         input logic [7:0] z);
      logic [7:0] acc;
      acc = 8'h0;
      for (int k = 0; k < 8; k++)
      begin
         if (z[k])
            acc = acc ^ (x << k);
      end
      return acc;
   endfunction : clmul8

   always_comb
   begin
      logic [8:0] sum;
      logic cin;
      logic [4:0] lb;
      logic [7:0] bb;
      sum = 9'h0;
      cin = 1'b0;
      lb = 5'(5'h1 << etype.size);
      bb = 8'h0;
      y = '0;
      for (int i = 0; i < NB; i++)
      begin
         bb = (op == OP_SUB) ? ~b[8*i +: 8] : b[8*i +: 8];
         // lane start cuts the carry chain
         if ((5'(i) & (lb - 5'h1)) == 5'h0)
            cin = (op == OP_SUB);
         sum = {1'b0, a[8*i +: 8]} + {1'b0, bb} + {8'h0, cin};
         cin = sum[8];
         unique case (op)
            OP_ADD, OP_SUB: y[8*i +: 8] = sum[7:0];
            OP_AND: y[8*i +: 8] = a[8*i +: 8] & b[8*i +: 8];
            OP_ORR: y[8*i +: 8] = a[8*i +: 8] | b[8*i +: 8];
            OP_XOR: y[8*i +: 8] = a[8*i +: 8] ^ b[8*i +: 8];
            OP_PMUL: y[8*i +: 8] = clmul8(a[8*i +: 8], b[8*i +: 8]);
            OP_FNEG, OP_FABS:
            begin
               y[8*i +: 8] = a[8*i +: 8];
               // sign bit sits in the top byte of each lane
               if (((5'(i) + 5'h1) & (lb - 5'h1)) == 5'h0)
                  y[8*i+7] = (op == OP_FNEG) ? ~a[8*i+7] : 1'b0;
            end
         endcase
      end
   end
endmodule : sfb_lane_alu
`default_nettype wire

// [design/sfb_pkg.sv]
/*
 * shared types and constants of the simd/scalar register bank.
 * assumes one core clock and synchronous active-high reset.
 */
package sfb_pkg;
   localparam int DREG_W = 64;
   localparam int QREG_W = 128;
   localparam int NUM_D = 32;
   localparam int NUM_Q = 16;
   localparam int IDX_W = 5;
   localparam logic [DREG_W-1:0] DREG_RST = 64'h0;
   // element size codes: lane width is 8 << code
   localparam logic [1:0] SZ_8 = 2'h0;
   localparam logic [1:0] SZ_16 = 2'h1;
   localparam logic [1:0] SZ_32 = 2'h2;
   localparam logic [1:0] SZ_64 = 2'h3;

   typedef enum logic [2:0] {OP_ADD, OP_SUB, OP_AND, OP_ORR, OP_XOR,
      OP_PMUL, OP_FNEG, OP_FABS} sfb_op_e;
   typedef enum logic [2:0] {K_UINT, K_SINT, K_INT, K_FLT, K_POLY}
      sfb_kind_e;

   typedef struct packed {
      sfb_kind_e kind;
      logic [1:0] size;
   } sfb_etype_s;

   typedef struct packed {
      logic valid;
      sfb_op_e op;
      sfb_etype_s etype;
      logic quad;
      logic [IDX_W-1:0] dst;
      logic [IDX_W-1:0] srca;
      logic [IDX_W-1:0] srcb;
   } sfb_vreq_s;

   typedef struct packed {
      logic [IDX_W-1:0] rd_idx;
      logic wr_en;
      logic [IDX_W-1:0] wr_idx;
      logic [DREG_W-1:0] wr_data;
   } sfb_sreq_s;
endpackage : sfb_pkg

// [testbench/sfb_pipe_model.sv]
/*
 * model of the vector and scalar execution pipelines feeding the bank.
 * assumes put() is called once per cycle at the falling edge of clk.
 */
`timescale 1ns/1ps
`default_nettype none
module sfb_pipe_model
   import sfb_pkg::*;
(
   input wire logic clk,
   output var sfb_pkg::sfb_vreq_s vreq,
   output var sfb_pkg::sfb_sreq_s sreq
);
   initial
   begin
      vreq = '0;
      sreq = '0;
   end

   // unqualified fields flip so a stale value can never pass as valid
   task automatic put(input sfb_vreq_s v, input sfb_sreq_s s);
      if (!v.valid)
      begin
         v = ~vreq;
         v.valid = 1'b0;
      end
      if (!s.wr_en)
      begin
         s.wr_idx = ~sreq.wr_idx;
         s.wr_data = ~sreq.wr_data;
      end
      vreq = v;
      sreq = s;
   endtask : put
endmodule : sfb_pipe_model
`default_nettype wire

// [testbench/simd_shared_register_bank_test.sv]
/*
 * self-checking bench of the shared bank: shadow copy, noted results.
 * assumes one 50 MHz clock and the pipeline model as request source.
 */
`timescale 1ns/1ps
`default_nettype none
module simd_shared_register_bank_test;
   import sfb_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   sfb_vreq_s vreq;
   sfb_sreq_s sreq;
   logic [QREG_W-1:0] vres_r;
   logic vdone_r;
   logic vrefused_r;
   logic [DREG_W-1:0] sdata_r;
   logic [DREG_W-1:0] sh [NUM_D];
   logic [QREG_W-1:0] last = '0;
   logic [129:0] vq [$];
   logic [DREG_W-1:0] sq [$];
   logic [31:0] seed = 32'h16da1;
   int failures = 0;
   int n_tests = 0;

   sfb_pipe_model pipe (.clk(clk), .vreq(vreq), .sreq(sreq));
   sfb_bank dut (.clk(clk), .sys_rst(sys_rst), .vreq(vreq),
      .vres_r(vres_r), .vdone_r(vdone_r), .vrefused_r(vrefused_r),
      .sreq(sreq), .sdata_r(sdata_r));

   initial
   begin
      forever #10 clk = ~clk;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   function automatic logic refuse(sfb_vreq_s v);
      logic f;
      logic p;
      f = v.etype.kind == K_FLT;
      p = v.etype.kind == K_POLY;
      return (v.quad && (v.dst[4] | v.srca[4] | v.srcb[4]))
         || v.etype.kind > K_POLY || (f != (v.op >= OP_FNEG))
         || (f && (v.etype.size == SZ_8 || v.etype.size == SZ_64))
         || (v.op == OP_PMUL && !(p && v.etype.size == SZ_8))
         || (p && v.op != OP_PMUL);
   endfunction : refuse

   // byte walk; carry restarts at every lane start
   function automatic logic [127:0] ref_op(logic [127:0] a, logic [127:0] b,
      sfb_op_e op, logic [1:0] sz);
      logic [127:0] r;
      logic [8:0] s;
      logic [7:0] nb;
      logic [7:0] p;
      logic c;
      int lb;
      lb = 1 << sz;
      c = 1'b0;
      for (int i = 0; i < 16; i++)
      begin
         if (i % lb == 0)
            c = op == OP_SUB;
         nb = op == OP_SUB ? ~b[i*8+:8] : b[i*8+:8];
         s = {1'b0, a[i*8+:8]} + {1'b0, nb} + {8'h0, c};
         c = s[8];
         p = '0;
         for (int j = 0; j < 8; j++)
            if (b[i*8+j])
               p ^= a[i*8+:8] << j;
         r[i*8+:8] = op == OP_PMUL ? p : s[7:0];
         if (op >= OP_FNEG)
            r[i*8+:8] = a[i*8+:8];
         if (op >= OP_FNEG && i % lb == lb - 1)
            r[i*8+7] = op == OP_FNEG ? ~a[i*8+7] : 1'b0;
      end
      if (op == OP_AND) r = a & b;
      if (op == OP_ORR) r = a | b;
      if (op == OP_XOR) r = a ^ b;
      return r;
   endfunction : ref_op

   task automatic chk(input logic [129:0] got, input logic [129:0] exp,
      input string m);
      n_tests++;
      if (got !== exp)
      begin
         failures++;
         $display("ERROR %0t %s mismatch", $time, m);
      end
   endtask : chk

   task automatic step(input sfb_vreq_s v, input sfb_sreq_s s);
      logic [127:0] a;
      logic [127:0] b;
      logic [127:0] r;
      logic rf;
      @(negedge clk);
      sq.push_back(sh[s.rd_idx]);
      rf = refuse(v);
      a = v.quad ? {sh[{v.srca[3:0], 1'b1}], sh[{v.srca[3:0], 1'b0}]}
         : {64'h0, sh[v.srca]};
      b = v.quad ? {sh[{v.srcb[3:0], 1'b1}], sh[{v.srcb[3:0], 1'b0}]}
         : {64'h0, sh[v.srcb]};
      r = ref_op(a, b, v.op, v.etype.size);
      if (!v.quad)
         r[127:64] = '0;
      if (v.valid && !rf)
         last = r;
      if (v.valid)
         vq.push_back({!rf, rf, last});
      if (s.wr_en)
         sh[s.wr_idx] = s.wr_data;
      // vector write wins over a scalar write to the same double
      if (v.valid && !rf && v.quad)
      begin
         sh[{v.dst[3:0], 1'b0}] = r[63:0];
         sh[{v.dst[3:0], 1'b1}] = r[127:64];
      end
      else if (v.valid && !rf)
         sh[v.dst] = r[63:0];
      pipe.put(v, s);
   endtask : step

   always
   begin
      @(posedge clk);
      #2;
      if ((vdone_r | vrefused_r) === 1'b1 && vq.size() == 0)
         chk(130'h1, 130'h0, "unexpected vector answer");
      else if ((vdone_r | vrefused_r) === 1'b1)
         chk({vdone_r, vrefused_r, vres_r}, vq.pop_front(),
            "vector");
      if (sq.size() != 0)
         chk(130'(sdata_r), 130'(sq.pop_front()),
            "scalar");
   end

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : end_of_test

   initial
   begin
      sfb_vreq_s v;
      sfb_sreq_s s;
      logic [31:0] k;
      int w;
      for (int i = 0; i < NUM_D; i++)
         sh[i] = DREG_RST;
      repeat (5) @(negedge clk);
      sys_rst = 1'b0;
      v = '0;
      for (int i = 0; i < NUM_D; i++)
      begin
         s = {i[4:0], 1'b1, i[4:0], rnd(), rnd()};
         if (i < 2)
            s.wr_data = i == 0 ? '1 : 64'h0101010101010101;
         step(v, s);
      end
      for (int z = 0; z < 4; z++)
      begin
         v = {1'b1, OP_ADD, K_UINT, 2'(z), 1'b0, 5'(2 + z), 5'h0, 5'h1};
         step(v, s);
      end
      for (int n = 0; n < 400; n++)
      begin
         k = rnd();
         v = {k[31:30] != 2'h0, k[2:0], k[7:5] % 3'h6, k[29:12]};
         if (k[9:8] != 2'h0)
         begin
            v.etype.kind = v.op == OP_PMUL ? K_POLY : v.op >= OP_FNEG ? K_FLT
               : sfb_kind_e'(k[11:10] % 2'h3);
            if (v.op == OP_PMUL) v.etype.size = SZ_8;
            if (v.op >= OP_FNEG) v.etype.size = {1'b0, k[12]} + 2'h1;
         end
         if (v.quad && k[31:29] != 3'h0)
            {v.dst[4], v.srca[4], v.srcb[4]} = 3'h0;
         k = rnd();
         s = {k[4:0], k[5], k[10:6], rnd(), rnd()};
         step(v, s);
      end
      v = '0;
      step(v, s);
      for (w = 0; w < 10 && (vq.size() != 0 || sq.size() != 0); w++)
         @(posedge clk);
      if (vq.size() != 0 || sq.size() != 0)
         chk(130'h1, 130'h0, "results missing");
      end_of_test();
   end
endmodule : simd_shared_register_bank_test
`default_nettype wire
